// ===== rtl/sbc_ctrl.sv
// Stepper focus/home sequencer and shutter bridge control
// ==========================================================================
// How it works
// - Config register bit 7 shows running flag
// - Flag clears itself when sequence ends
// - Focus start phases: a high, b low, c high, d low
// - Focus sequence steps at 500 pulses per second
// - Focus hold equal before and after stepping
// - Home sequence steps at 100 pulses per second
// - Command write starts home sequence when enabled
// - Config bit 5 adds 64 home steps
// - Home hold matches neighbouring hold interval
// - Bridge mode: Z, forward, reverse, brake
// - Bridge enable bit 2: standby or operation
// - Current code 0 is 260mA, minus 10mA
// - Half-step cycle spans eight timebase periods
// - Config bit 3 selects half-step drive
`include "sbc_defines.svh"
`default_nettype none
module sbc_ctrl #(
	parameter logic [17:0] FOCUS_PERIOD = 18'(`SBC_FOCUS_PERIOD_CYC),
	parameter logic [17:0] HOME_PERIOD  = 18'(`SBC_HOME_PERIOD_CYC)
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// Register port from the serial front end
	input  wire sbc_pkg::sbc_reg_s reg_port,
	output logic [7:0]             reg_rdata,
	// Stepper phase pins
	output sbc_pkg::sbc_pin_s      phase_out_a,
	output sbc_pkg::sbc_pin_s      phase_out_b,
	output sbc_pkg::sbc_pin_s      phase_out_c,
	// Shutter bridge pins (first pin is shared with stepper phase d)
	output sbc_pkg::sbc_pin_s      bridge_out_first,
	output sbc_pkg::sbc_pin_s      bridge_out_second,
	// Status and current setting
	output logic                   sequence_running_flag,
	output logic                   shutter_enabled,
	output logic [3:0]             current_code,
	output logic [8:0]             current_ma
);
	import sbc_pkg::*;

	// ======================================================================
	// Functions

	// Phase pattern {a,b,c,d} for a position in the eight-step table
	function automatic logic [3:0] phase_pattern(input logic [2:0] idx);
		logic [3:0] p;
		p = 4'h0;
		unique case (idx)
			3'h0: p = 4'b1010;
			3'h1: p = 4'b0010;
			3'h2: p = 4'b0110;
			3'h3: p = 4'b0100;
			3'h4: p = 4'b0101;
			3'h5: p = 4'b0001;
			3'h6: p = 4'b1001;
			3'h7: p = 4'b1000;
		endcase
		return p;
	endfunction

	// Hold pulse count from the three-bit hold setting
	function automatic logic [7:0] hold_pulses(input logic [2:0] sel);
		logic [7:0] n;
		n = 8'h01;
		unique case (sel)
			3'h0: n = 8'h01;
			3'h1: n = 8'h02;
			3'h2: n = 8'h04;
			3'h3: n = 8'h05;
			3'h4: n = 8'h08;
			3'h5: n = 8'h10;
			3'h6: n = 8'h20;
			3'h7: n = 8'h01;
		endcase
		return n;
	endfunction

	// Drive a pin from a level, or release it
	function automatic sbc_pin_s pin(input logic drive, input logic lvl);
		sbc_pin_s p;
		p.level = drive ? lvl : 1'b0;
		p.oe_b  = !drive;
		return p;
	endfunction

	// ======================================================================
	// Reset synchroniser
	logic [1:0] rst_sync_reg;
	logic       rst_int_b;

	// Async assert, clocked release through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_int_b = rst_sync_reg[1];

	// ======================================================================
	// Registers
	logic [7:0] cmd_reg;
	logic [5:0] cfg_reg;
	logic [1:0] bmode_reg;
	logic       ben_reg;
	logic [3:0] cur_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic       wr_cmd;
	logic       wr_cfg;
	logic       wr_bmode;
	logic       wr_ben;
	logic       wr_cur;
	logic       running;

	// Address decode; command writes are dropped while a sequence runs
	assign wr_cmd   = reg_port.wr && reg_port.addr == `SBC_OFS_STEP_CMD
		&& !running;
	assign wr_cfg   = reg_port.wr && reg_port.addr == `SBC_OFS_SEQ_CFG;
	assign wr_bmode = reg_port.wr && reg_port.addr == `SBC_OFS_BRIDGE_MODE;
	assign wr_ben   = reg_port.wr && reg_port.addr == `SBC_OFS_BRIDGE_EN;
	assign wr_cur   = reg_port.wr && reg_port.addr == `SBC_OFS_CURRENT;

	// Host-written fields, all zero out of reset
	always_ff @(posedge core_clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			cmd_reg   <= `SBC_RST_CMD;
			cfg_reg   <= `SBC_RST_CFG;
			bmode_reg <= `SBC_RST_BMODE;
			ben_reg   <= 1'b0;
			cur_reg   <= `SBC_RST_CUR;
		end else begin
			if (wr_cmd) cmd_reg <= reg_port.data;
			if (wr_cfg) cfg_reg <= reg_port.data[5:0];
			if (wr_bmode) bmode_reg <= reg_port.data[`SBC_BMODE_MSB:0];
			if (wr_ben) ben_reg <= reg_port.data[`SBC_BEN_BIT];
			if (wr_cur) cur_reg <= reg_port.data[`SBC_CUR_MSB:0];
		end
	end

	// Read mux; unused upper bits and unmapped offsets read zero
	always_comb begin
		rdata_next = 8'h00;
		unique case (reg_port.addr)
			`SBC_OFS_STEP_CMD:    rdata_next = cmd_reg;
			`SBC_OFS_SEQ_CFG:     rdata_next = {running, 1'b0, cfg_reg};
			`SBC_OFS_BRIDGE_MODE: rdata_next = {6'h00, bmode_reg};
			`SBC_OFS_BRIDGE_EN:   rdata_next = {5'h00, ben_reg, 2'b00};
			`SBC_OFS_CURRENT:     rdata_next = {4'h0, cur_reg};
			default:              rdata_next = 8'h00;
		endcase
	end

	// Read data is registered, valid one cycle after the address
	always_ff @(posedge core_clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ======================================================================
	// Sequence start decode
	logic       home_en;
	logic       half_step;
	logic       start_home;
	logic       start_focus;
	logic [7:0] base_steps;
	logic [7:0] home_steps;
	logic [7:0] hold_n;

	assign home_en     = cfg_reg[`SBC_CFG_HOME_BIT];
	assign half_step   = cfg_reg[`SBC_CFG_HALF_BIT];
	// Home wins when enabled; otherwise the focus bit requests a focus run
	assign start_home  = wr_cmd && home_en;
	assign start_focus = wr_cmd && !home_en
		&& reg_port.data[`SBC_CMD_FOCUS_BIT];
	// Step code n gives 2*(n+1) steps
	assign base_steps  = {2'b00, reg_port.data[`SBC_CMD_STEPS_MSB:
		`SBC_CMD_STEPS_LSB], 1'b0} + 8'h02;
	assign home_steps  = base_steps + (cfg_reg[`SBC_CFG_PLUS64_BIT] ?
		`SBC_PLUS64_STEPS : 8'h00);
	// Hold setting is sampled from the config already written
	assign hold_n      = hold_pulses(cfg_reg[`SBC_CFG_HOLD_MSB:0]);

	// ======================================================================
	// Sequencer state
	sbc_state_e state_reg;
	sbc_state_e state_next;
	logic       home_reg;
	logic       dir_reg;
	logic [7:0] steps_reg;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [2:0] idx_reg;
	logic [2:0] idx_next;
	logic [2:0] idx_inc;
	logic       tick;
	logic       last;

	assign running = state_reg != ST_IDLE;
	assign last    = cnt_reg == 8'h01;
	// Full step moves two table entries so a cycle is four periods;
	// half step moves one, so a cycle is eight periods
	assign idx_inc = half_step ? 3'h1 : 3'h2;
	assign idx_next = dir_reg ? idx_reg - idx_inc : idx_reg + idx_inc;

	// Pulse rate depends on which sequence runs
	sbc_pulse_gen u_pulse (
		.core_clk (core_clk),
		.rst_b    (rst_int_b),
		.run      (running),
		.period   (home_reg ? HOME_PERIOD : FOCUS_PERIOD),
		.tick     (tick)
	);

	// Next state: pre-hold, stepping, post-hold, then idle
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_home || start_focus) begin
					state_next = ST_PRE;
					cnt_next   = hold_n;
				end
			end
			ST_PRE: begin
				if (tick) begin
					cnt_next = cnt_reg - 8'h01;
					if (last) begin
						state_next = ST_STEP;
						cnt_next   = steps_reg;
					end
				end
			end
			ST_STEP: begin
				if (tick) begin
					cnt_next = cnt_reg - 8'h01;
					if (last) begin
						// Same hold setting front and rear
						state_next = ST_POST;
						cnt_next   = hold_n;
					end
				end
			end
			ST_POST: begin
				if (tick) begin
					cnt_next = cnt_reg - 8'h01;
					if (last) begin
						state_next = ST_IDLE;
					end
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge core_clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 8'h00;
			steps_reg <= 8'h00;
			home_reg  <= 1'b0;
			dir_reg   <= 1'b0;
			idx_reg   <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (state_reg == ST_IDLE && (start_home || start_focus)) begin
				home_reg  <= start_home;
				dir_reg   <= reg_port.data[`SBC_CMD_DIR_BIT];
				steps_reg <= start_home ? home_steps : base_steps;
				idx_reg   <= 3'h0;
			end else if (state_reg == ST_STEP && tick) begin
				idx_reg <= idx_next;
			end
		end
	end

	// ======================================================================
	// Output pins
	logic [3:0] phase;
	logic       br_drive;
	logic       br_first;
	logic       br_second;

	assign phase = phase_pattern(idx_reg);

	// Bridge decode; both outputs released in standby or mode 00
	assign br_drive  = ben_reg && bmode_reg != 2'b00;
	assign br_first  = bmode_reg == 2'b01;
	assign br_second = bmode_reg == 2'b10;

	// Phase pins only drive while a sequence runs; shared pin goes to
	// the stepper then, since both cannot own it at once
	assign phase_out_a       = pin(running, phase[3]);
	assign phase_out_b       = pin(running, phase[2]);
	assign phase_out_c       = pin(running, phase[1]);
	assign bridge_out_first  = running ? pin(1'b1, phase[0])
		: pin(br_drive, br_first);
	assign bridge_out_second = pin(br_drive && !running, br_second);

	// Status and current outputs
	assign sequence_running_flag = running;
	assign shutter_enabled       = ben_reg;
	assign current_code          = cur_reg;
	assign current_ma            = `SBC_CUR_MAX_MA -
		9'(cur_reg) * `SBC_CUR_STEP_MA;
	assign reg_rdata             = rdata_reg;
endmodule
`default_nettype wire

// ===== rtl/sbc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ==========================================================================
// Register offsets
`define SBC_OFS_STEP_CMD     3'h0
`define SBC_OFS_SEQ_CFG      3'h1
`define SBC_OFS_BRIDGE_MODE  3'h2
`define SBC_OFS_BRIDGE_EN    3'h3
`define SBC_OFS_CURRENT      3'h4

// ==========================================================================
// Field positions
`define SBC_CMD_FOCUS_BIT    0
`define SBC_CMD_DIR_BIT      1
`define SBC_CMD_STEPS_LSB    3
`define SBC_CMD_STEPS_MSB    7
`define SBC_CFG_HOLD_LSB     0
`define SBC_CFG_HOLD_MSB     2
`define SBC_CFG_HALF_BIT     3
`define SBC_CFG_HOME_BIT     4
`define SBC_CFG_PLUS64_BIT   5
`define SBC_CFG_FLAG_BIT     7
`define SBC_BMODE_LSB        0
`define SBC_BMODE_MSB        1
`define SBC_BEN_BIT          2
`define SBC_CUR_LSB          0
`define SBC_CUR_MSB          3

// ==========================================================================
// Reset values
`define SBC_RST_CMD          8'h00
`define SBC_RST_CFG          6'h00
`define SBC_RST_BMODE        2'h0
`define SBC_RST_CUR          4'h0

// ==========================================================================
// Timing: rates in pulses per second, clock period in ns
`define SBC_CLK_PERIOD_NS    50
`define SBC_FOCUS_RATE_PPS   500
`define SBC_HOME_RATE_PPS    100
`define SBC_FOCUS_PERIOD_CYC \
	(1000000000 / (`SBC_FOCUS_RATE_PPS * `SBC_CLK_PERIOD_NS))
`define SBC_HOME_PERIOD_CYC \
	(1000000000 / (`SBC_HOME_RATE_PPS * `SBC_CLK_PERIOD_NS))

// ==========================================================================
// Current code mapping in mA, and the home step extension count
`define SBC_CUR_MAX_MA       9'h104
`define SBC_CUR_STEP_MA      9'h00a
`define SBC_PLUS64_STEPS     8'h40

`endif

// ===== rtl/sbc_pkg.sv
// Types shared by the stepper sequence and bridge control block
`default_nettype none
package sbc_pkg;
	// Register write/read port from the serial front end
	typedef struct packed {
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
	} sbc_reg_s;

	// One output pin: level and active-low output enable
	typedef struct packed {
		logic level;
		logic oe_b;
	} sbc_pin_s;

	// Sequence phases
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE  = 2'b01,
		ST_STEP = 2'b10,
		ST_POST = 2'b11
	} sbc_state_e;
endpackage
`default_nettype wire

// ===== rtl/sbc_pulse_gen.sv
// Stepper pulse timebase: one tick per programmed period while running
`default_nettype none
module sbc_pulse_gen (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Control
	input  wire logic        run,
	input  wire logic [17:0] period,
	// Timebase tick
	output logic             tick
);
	logic [17:0] cnt_reg;
	logic [17:0] cnt_next;
	logic        wrap;

	// Counter restarts whenever the sequence is idle so the first pulse
	// always comes one full period after the start
	assign wrap     = run && (cnt_reg == period - 18'h0_0001);
	assign cnt_next = (!run || wrap) ? 18'h0_0000 : cnt_reg + 18'h0_0001;
	assign tick     = wrap;

	// Period counter
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 18'h0_0000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

// ===== verif/sbc_ctrl_monitor.sv
// Assertion checker for the stepper sequencer and shutter bridge
`default_nettype none
module sbc_ctrl_monitor
	import sbc_pkg::*;
#(
	parameter logic [17:0] FOCUS_PERIOD = 18'h0_0008,
	parameter logic [17:0] HOME_PERIOD  = 18'h0_0010
) (
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              rst_b,
	// Register port
	input wire sbc_pkg::sbc_reg_s reg_port,
	input wire logic [7:0]        reg_rdata,
	// Pins
	input wire sbc_pkg::sbc_pin_s phase_out_a,
	input wire sbc_pkg::sbc_pin_s phase_out_b,
	input wire sbc_pkg::sbc_pin_s phase_out_c,
	input wire sbc_pkg::sbc_pin_s bridge_out_first,
	input wire sbc_pkg::sbc_pin_s bridge_out_second,
	// Status
	input wire logic              sequence_running_flag,
	input wire logic              shutter_enabled,
	input wire logic [3:0]        current_code,
	input wire logic [8:0]        current_ma
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==================================================================
	// Shadow fields: pins can only be predicted from what the host wrote
	localparam int LIMIT = 192 * int'(HOME_PERIOD) + 64;
	logic [1:0]  mode_q;
	logic        en_q, half_q, home_q, flag_q, moved_q;
	logic [3:0]  vec_q;
	logic [17:0] gap_q;
	int          run_q;
	wire logic flag = sequence_running_flag;
	wire logic wr_cfg = reg_port.wr && reg_port.addr == 3'h1;
	wire logic wr_mode = reg_port.wr && reg_port.addr == 3'h2;
	wire logic wr_en = reg_port.wr && reg_port.addr == 3'h3;
	wire logic [3:0] vec = {phase_out_a.level, phase_out_b.level,
		phase_out_c.level, bridge_out_first.level};
	wire logic step = flag && flag_q && vec != vec_q;
	wire logic on = en_q && mode_q != 2'h0;
	wire logic [17:0] per = home_q ? HOME_PERIOD : FOCUS_PERIOD;
	// Gap counter restarts at each phase change, so it measures the rate
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{mode_q, en_q, half_q, home_q} <= '0;
			{flag_q, moved_q, vec_q, gap_q} <= '0;
			run_q <= 0;
		end else begin
			if (wr_cfg) {home_q, half_q} <= reg_port.data[4:3];
			if (wr_mode) mode_q <= reg_port.data[1:0];
			if (wr_en) en_q <= reg_port.data[2];
			flag_q <= flag;
			vec_q <= vec;
			moved_q <= flag && (moved_q || step);
			gap_q <= step ? 18'h0_0001 : gap_q + 18'h0_0001;
			run_q <= flag ? run_q + 1 : 0;
		end
	end
	// ==================================================================
	// Assertions
	a_cur_map: assert property (
		current_ma == 9'(260 - 10 * int'(current_code)))
		else $error("current value does not follow the code");
	a_start_cmd: assert property (!flag && reg_port.wr &&
		reg_port.addr == 3'h0 && (reg_port.data[0] || home_q) |=> flag)
		else $error("sequence did not start");
	a_start_phase: assert property ($rose(flag) |-> vec == 4'ha &&
		!phase_out_a.oe_b && !bridge_out_first.oe_b)
		else $error("wrong start phases");
	a_run_pins: assert property (flag |-> !phase_out_b.oe_b &&
		!phase_out_c.oe_b && bridge_out_second.oe_b)
		else $error("pin ownership wrong while running");
	a_step_rate: assert property (
		step && moved_q |-> gap_q == per)
		else $error("step rate wrong");
	a_step_size: assert property (step |->
		$countones(vec ^ vec_q) == (half_q ? 1 : 2))
		else $error("step size wrong for drive mode");
	a_flag_bound: assert property (run_q < LIMIT)
		else $error("running flag never cleared");
	a_bridge_pins: assert property (!flag |->
		shutter_enabled == en_q &&
		bridge_out_first.oe_b == !on && bridge_out_second.oe_b == !on &&
		(!on || bridge_out_first.level == (mode_q == 2'h1) &&
		bridge_out_second.level == (mode_q == 2'h2)))
		else $error("bridge pins do not follow mode");
	a_reset_idle: assert property ($rose(rst_b) |-> !flag &&
		current_ma == 9'h104 && phase_out_a.oe_b && bridge_out_first.oe_b)
		else $error("not idle after reset");
	a_flag_read: assert property ($past(reg_port.addr) == 3'h1 |->
		reg_rdata[7] == $past(flag))
		else $error("flag bit reads wrong");
	c_home_run: cover property ($rose(flag) && home_q);
	c_half_step: cover property (step && half_q);
	c_brake: cover property (!flag && on && mode_q == 2'h3);
endmodule

bind sbc_ctrl sbc_ctrl_monitor #(
	.FOCUS_PERIOD(FOCUS_PERIOD), .HOME_PERIOD(HOME_PERIOD)
) u_mon (
	.core_clk(core_clk), .rst_b(rst_b), .reg_port(reg_port),
	.reg_rdata(reg_rdata), .phase_out_a(phase_out_a),
	.phase_out_b(phase_out_b), .phase_out_c(phase_out_c),
	.bridge_out_first(bridge_out_first),
	.bridge_out_second(bridge_out_second),
	.sequence_running_flag(sequence_running_flag),
	.shutter_enabled(shutter_enabled), .current_code(current_code),
	.current_ma(current_ma)
);
`default_nettype wire

// ===== verif/sbc_ctrl_test.sv
// Self-checking testbench for the stepper sequencer and shutter bridge
`default_nettype none
module sbc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sbc_pkg::*;
	localparam logic [17:0] FP = 18'h0_0008;
	localparam logic [17:0] HP = 18'h0_0010;
	localparam int LIMIT = 20000;
	localparam int HOLD [8] = '{1, 2, 4, 5, 8, 16, 32, 1};
	localparam logic [3:0] PH [8] = '{4'ha, 4'h2, 4'h6, 4'h4,
		4'h5, 4'h1, 4'h9, 4'h8};
	logic       core_clk, rst_b, flag, shutter_on;
	int         fails, tests_run;
	int         cyc = 0;
	sbc_reg_s   reg_port;
	sbc_pin_s   pa, pb, pc, pf, ps;
	logic [7:0] reg_rdata, r;
	logic [3:0] ccode;
	logic [8:0] cma;
	wire logic [3:0] vec = {pa.level, pb.level, pc.level, pf.level};

	sbc_host u_host (.core_clk(core_clk), .reg_port(reg_port),
		.reg_rdata(reg_rdata));
	sbc_ctrl #(.FOCUS_PERIOD(FP), .HOME_PERIOD(HP)) u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_port(reg_port),
		.reg_rdata(reg_rdata), .phase_out_a(pa), .phase_out_b(pb),
		.phase_out_c(pc), .bridge_out_first(pf), .bridge_out_second(ps),
		.sequence_running_flag(flag), .shutter_enabled(shutter_on),
		.current_code(ccode), .current_ma(cma));

	// ==================================================================
	// Clock, hang guard and reporting
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			$display("ERROR t=%0t cycle ceiling reached", $time);
			end_of_test();
		end
	end
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR t=%0t %s", $time, msg);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==================================================================
	// One sequence; a second command is thrown at it while it runs
	task automatic run_seq(input logic [7:0] cfg, input logic [7:0] cmd);
		int h, s, p, d, n, k, t;
		logic [3:0] first, prev;
		h = HOLD[cfg[2:0]];
		s = 2 * int'(cmd[7:3]) + 2 + ((cfg[4] && cfg[5]) ? 64 : 0);
		p = int'(cfg[4] ? HP : FP);
		k = cfg[3] ? 1 : 2;
		if (cmd[1]) k = 8 - k;
		d = 0;
		n = 0;
		first = 4'h0;
		t = (2 * h + s) * p;
		u_host.start(cfg, cmd);
		fork
			begin
				u_host.wr(3'h0, 8'hff);
				u_host.rd(3'h1, r);
				check(r[7] === 1'b1, "flag low while running");
			end
			begin
				@(posedge core_clk);
				check(vec === 4'ha && flag === 1'b1, "bad start");
				prev = vec;
				while (flag === 1'b1 && d < LIMIT) begin
					if (vec !== prev) begin
						n++;
						if (n == 1) first = vec;
					end
					prev = vec;
					d++;
					@(posedge core_clk);
				end
			end
		join
		check(n == s, "step count wrong");
		check(d >= t - 2 && d <= t + 2, "time wrong");
		check(first === PH[k], "direction or drive mode wrong");
		u_host.rd(3'h0, r);
		check(r === cmd && flag === 1'b0, "busy command taken");
		$display("done: sequence cfg %h cmd %h", cfg, cmd);
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		fails = 0;
		tests_run = 0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		u_host.wr(3'h5, 8'hff);
		for (int a = 0; a < 6; a++) begin
			u_host.rd(3'(a), r);
			check(r === 8'h00, "register not clear");
		end
		check({pa.oe_b, pb.oe_b, pc.oe_b, pf.oe_b,
			ps.oe_b} === 5'h1f, "driven");
		$display("done: reset values");
		u_host.wr(3'h3, 8'h04);
		for (int m = 0; m < 4; m++) begin
			u_host.wr(3'h2, 8'(m));
			@(posedge core_clk);
			check(pf.oe_b === 1'(m == 0) &&
				ps.oe_b === 1'(m == 0), "enable");
			check(m == 0 || pf.level === 1'(m == 1) &&
				ps.level === 1'(m == 2), "level");
		end
		u_host.wr(3'h3, 8'h00);
		@(posedge core_clk);
		check(pf.oe_b === 1'b1 && ps.oe_b === 1'b1 &&
			shutter_on === 1'b0, "standby");
		u_host.rd(3'h2, r);
		check(r[1:0] === 2'h3, "mode readback");
		$display("done: bridge");
		for (int c = 0; c < 16; c++) begin
			u_host.wr(3'h4, 8'(c));
			@(posedge core_clk);
			check(cma === 9'(260 - 10 * c) &&
				ccode === 4'(c), "current");
		end
		$display("done: current");
		for (int h = 0; h < 8; h++) run_seq(8'(h), 8'h01);
		run_seq(8'h08, 8'h0b);
		run_seq(8'h0a, 8'h19);
		run_seq(8'h01, 8'h1b);
		run_seq(8'h20, 8'h01);
		run_seq(8'h10, 8'h00);
		run_seq(8'h31, 8'h00);
		u_host.start(8'h00, 8'hf8);
		repeat (3) @(posedge core_clk);
		check(flag === 1'b0, "disabled command started");
		$display("done: idle command");
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== verif/sbc_host.sv
// Host model that writes and reads the block's registers
`default_nettype none
module sbc_host
	import sbc_pkg::*;
(
	// Clock
	input wire logic              core_clk,
	// Register port toward the block
	output var sbc_pkg::sbc_reg_s reg_port,
	input wire logic [7:0]        reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus idle at time zero
	initial reg_port = '0;
	// One write, held for exactly the edge that takes it
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_port.wr <= 1'b1;
		reg_port.addr <= a;
		reg_port.data <= d;
		@(posedge core_clk);
		reg_port.wr <= 1'b0;
		reg_port.data <= ~d; // Stale data must not look valid
	endtask
	// One read, address held until the registered answer is taken
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_port.addr <= a;
		@(posedge core_clk);
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	// Launch: hold time and mode always go in before the command
	task automatic start(input logic [7:0] cfg, input logic [7:0] cmd);
		wr(3'h1, cfg);
		wr(3'h0, cmd);
	endtask
endmodule
`default_nettype wire
